// ===== rtl/pab_defines.svh
`ifndef PAB_DEFINES_SVH
`define PAB_DEFINES_SVH

// Register byte offsets on the APB slave
`define PAB_OFF_DEF_ATTRS 12'h000
`define PAB_OFF_STATUS    12'h004
`define PAB_OFF_COUNT     12'h008
`define PAB_OFF_CFG       12'h00c

// Page storage attribute group: reset value and bit positions
`define PAB_ATTRS_RESET   5'h08
`define PAB_ATTR_W        4
`define PAB_ATTR_I        3
`define PAB_ATTR_M        2
`define PAB_ATTR_G        1
`define PAB_ATTR_E        0

// Configuration register: coherence enable bit and its reset value
`define PAB_CFG_COH_EN    0
`define PAB_CFG_RESET     1'b1

// Sticky status bits
`define PAB_ST_UNSUP      0
`define PAB_ST_MISAL      1

// Bytes per memory beat
`define PAB_BEAT_BYTES    4'h8

`endif

// ===== rtl/pab_pkg.sv
package pab_pkg;

	// Request kinds coming from the load/store and fetch pipeline
	typedef enum logic [3:0] {
		KIND_LOAD,
		KIND_STORE,
		KIND_LSW,
		KIND_STSW,
		KIND_DCBZ,
		KIND_CMO,
		KIND_ICBI,
		KIND_ISYNC,
		KIND_FETCH
	} pab_kind_type;

	typedef enum logic [1:0] {
		SZ_BYTE,
		SZ_HALF,
		SZ_WORD,
		SZ_DWORD
	} pab_size_type;

	// Operations handed to the cache and memory side
	typedef enum logic [2:0] {
		MOP_READ,
		MOP_WRITE,
		MOP_ZERO,
		MOP_CMO,
		MOP_ICBI
	} pab_mop_type;

	typedef enum {
		ST_IDLE,
		ST_WAIT
	} pab_state_type;

	typedef struct packed {
		logic         valid;
		pab_kind_type kind;
		pab_size_type size;
		logic [31:0]  addr;
		logic [63:0]  data;
		logic [3:0]   str_len;
		logic         attrs_valid;
		logic [4:0]   attrs;
	} pab_req_type;

	typedef struct packed {
		logic        valid;
		pab_mop_type op;
		logic [31:0] addr;
		logic [7:0]  be;
		logic [63:0] data;
		logic        wt;
		logic        ci;
		logic        coh;
		logic        grd;
	} pab_mem_req_type;

	typedef struct packed {
		logic        valid;
		logic [63:0] data;
	} pab_mem_rsp_type;

	typedef struct packed {
		logic        valid;
		logic        err;
		logic [63:0] data;
	} pab_done_type;

endpackage : pab_pkg

// ===== rtl/pab_page_attribute_byte_order.sv
`timescale 1ns/1ps
`include "pab_defines.svh"
module pab_page_attribute_byte_order
#(
	parameter bit COH_SUPPORTED = 1'b1
)
(
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire pab_pkg::pab_req_type     req,
	output logic                          req_ready,
	output pab_pkg::pab_mem_req_type      mem_req,
	input  wire pab_pkg::pab_mem_rsp_type mem_rsp,
	output pab_pkg::pab_done_type         done,
	output logic                          fetch_flush
);
	import pab_pkg::*;

	logic [4:0]       def_attrs_r;
	logic             coh_en_r;
	logic [1:0]       status_r;
	logic [31:0]      count_r;
	logic [31:0]      prdata_r;
	logic             pready_r;
	logic             pslverr_r;
	logic             req_ready_r;
	logic             fetch_flush_r;
	pab_mem_req_type  mem_req_r;
	pab_done_type     done_r;
	pab_state_type    state_r;
	logic [7:0]       ld_be_r;
	logic [7:0][2:0]  ld_src_r;

	logic [4:0]       attrs;
	logic [2:0]       off;
	logic [3:0]       nbytes;
	logic             is_str;
	logic             is_read;
	logic             is_data;
	logic             is_zero;
	logic             chk;
	logic             unsup;
	logic             misal;
	logic             bad;
	logic             take;
	logic             issue;
	logic             rd_ret;
	pab_mop_type      mop;
	logic [7:0]       lane_be;
	logic [7:0][2:0]  lane_src;
	logic [63:0]      lane_wd;
	logic [63:0]      ld_nxt;

	logic             setup;
	logic             wr_acc;
	logic             hit;
	logic [31:0]      rd_mux;
	logic [1:0]       st_set;
	logic [1:0]       st_clr;

	// Request decode
	assign take = req.valid & req_ready_r;
	// A request without its own attributes uses the held default group
	assign attrs = req.attrs_valid ? req.attrs : def_attrs_r;
	assign off = req.addr[2:0];
	assign is_str = (req.kind == KIND_LSW) || (req.kind == KIND_STSW);
	assign is_read = (req.kind == KIND_LOAD) || (req.kind == KIND_LSW) || (req.kind == KIND_FETCH);
	assign is_data = is_read || (req.kind == KIND_STORE) || (req.kind == KIND_STSW);
	assign is_zero = (req.kind == KIND_DCBZ);

	// Access length in bytes; a string length of 0 or above 8 means a full beat
	always_comb
	begin
		if (is_str)
			nbytes = ((req.str_len == 4'h0) || (req.str_len > `PAB_BEAT_BYTES)) ? `PAB_BEAT_BYTES : req.str_len;
		else
			nbytes = 4'h1 << req.size;
	end

	// Attribute check; G and E never enter it, so any value of them passes
	assign unsup = (attrs[`PAB_ATTR_W] & attrs[`PAB_ATTR_I])
		| (attrs[`PAB_ATTR_M] & ~(COH_SUPPORTED & coh_en_r));
	// An access must stay inside one 8-byte beat
	assign misal = is_data & (({1'b0, off} + nbytes) > `PAB_BEAT_BYTES);
	// Cache-management ops other than dcbz skip the check, even on cached CI lines
	assign chk = is_data | is_zero;
	// No alias comparison: differing W, G or E between aliases is never refused
	assign bad = chk & (unsup | misal);
	// Taken, passes the check and needs a memory beat; isync never does
	assign issue = take & ~bad & (req.kind != KIND_ISYNC);
	assign rd_ret = (state_r == ST_WAIT) & mem_rsp.valid;

	// Byte steering per memory lane; lane k is address offset k
	for (genvar k = 0; k < 8; k++)
	begin : g_lane
		logic [2:0] j;
		logic [2:0] sidx;

		assign j = 3'(k) - off;
		// Big-endian reverses within the access size, little-endian is straight
		assign sidx = attrs[`PAB_ATTR_E] ? j : 3'(nbytes - 4'h1) - j;
		// String byte j goes to the leftmost free byte of word j/4
		assign lane_src[k] = is_str ? {j[2], ~j[1:0]} : sidx;
		assign lane_be[k] = (3'(k) >= off) && ({1'b0, j} < nbytes);
		assign lane_wd[8*k +: 8] = req.data[8*lane_src[k] +: 8];
	end

	// Load gather uses the same lane map as the store, so reads round-trip
	always_comb
	begin
		ld_nxt = 64'h0;
		for (int k = 0; k < 8; k++)
		begin
			if (ld_be_r[k])
				ld_nxt[8*ld_src_r[k] +: 8] = mem_rsp.data[8*k +: 8];
		end
	end

	// Memory operation for each request kind
	always_comb
	begin
		unique case (req.kind)
			KIND_LOAD, KIND_LSW, KIND_FETCH: mop = MOP_READ;
			KIND_STORE, KIND_STSW:           mop = MOP_WRITE;
			KIND_DCBZ:                       mop = MOP_ZERO;
			KIND_ICBI:                       mop = MOP_ICBI;
			default:                         mop = MOP_CMO;
		endcase
	end

	// Sequencer; one read outstanding keeps the gather map simple
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			state_r <= ST_IDLE;
			req_ready_r <= 1'b1;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE:
				begin
					// A read closes the port until memory answers
					if (issue && is_read)
					begin
						state_r <= ST_WAIT;
						req_ready_r <= 1'b0;
					end
				end
				ST_WAIT:
				begin
					if (mem_rsp.valid)
					begin
						state_r <= ST_IDLE;
						req_ready_r <= 1'b1;
					end
				end
			endcase
		end
	end

	// Memory beat; a one-cycle pulse whose fields hold until the next beat
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			mem_req_r <= '0;
		else
		begin
			mem_req_r.valid <= issue;
			if (issue)
			begin
				mem_req_r.op <= mop;
				mem_req_r.addr <= {req.addr[31:3], 3'h0};
				mem_req_r.be <= is_zero ? 8'hff : (is_data ? lane_be : 8'h0);
				mem_req_r.data <= is_zero ? 64'h0 : lane_wd;
				// Attributes travel with the beat so memory keeps coherence
				mem_req_r.wt <= attrs[`PAB_ATTR_W];
				mem_req_r.ci <= attrs[`PAB_ATTR_I];
				mem_req_r.coh <= attrs[`PAB_ATTR_M];
				mem_req_r.grd <= attrs[`PAB_ATTR_G];
			end
		end
	end

	// Completion; a refused request answers at once with its error set
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			done_r <= '0;
		else
		begin
			done_r.valid <= 1'b0;
			if (take)
			begin
				// A read answers later, from the gathered memory word
				done_r.valid <= ~(issue & is_read);
				done_r.err <= bad;
				done_r.data <= 64'h0;
			end
			else if (rd_ret)
			begin
				done_r.valid <= 1'b1;
				done_r.err <= 1'b0;
				done_r.data <= ld_nxt;
			end
		end
	end

	// Drops the fetch buffer the cycle after any taken isync, prior block invalidate or not
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			fetch_flush_r <= 1'b0;
		else
			fetch_flush_r <= take & (req.kind == KIND_ISYNC);
	end

	// Lane map of the outstanding read; the gather must not follow the live request
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ld_be_r <= 8'h0;
			ld_src_r <= '0;
		end
		else if (issue && is_read)
		begin
			ld_be_r <= lane_be;
			ld_src_r <= lane_src;
		end
	end

	// APB decode; the slave answers with no wait state
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pready_r & pwrite;
	assign hit = (paddr == `PAB_OFF_DEF_ATTRS) || (paddr == `PAB_OFF_STATUS)
		|| (paddr == `PAB_OFF_COUNT) || (paddr == `PAB_OFF_CFG);

	always_comb
	begin
		unique case (paddr)
			`PAB_OFF_DEF_ATTRS: rd_mux = {27'h0, def_attrs_r};
			`PAB_OFF_STATUS:    rd_mux = {30'h0, status_r};
			`PAB_OFF_COUNT:     rd_mux = count_r;
			`PAB_OFF_CFG:       rd_mux = {31'h0, coh_en_r};
			default:            rd_mux = 32'h0;
		endcase
	end

	// Answer is prepared at the setup edge and shown during the access cycle
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end
		else
		begin
			pready_r <= setup;
			pslverr_r <= setup & ~hit;
			prdata_r <= (setup & ~pwrite) ? rd_mux : 32'h0;
		end
	end

	// Default attribute group, writable by software
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			def_attrs_r <= `PAB_ATTRS_RESET;
		else if (wr_acc && (paddr == `PAB_OFF_DEF_ATTRS))
			def_attrs_r <= pwdata[4:0];
	end

	// Coherence support enable; has no effect when the build leaves it out
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			coh_en_r <= `PAB_CFG_RESET;
		else if (wr_acc && (paddr == `PAB_OFF_CFG))
			coh_en_r <= pwdata[`PAB_CFG_COH_EN];
	end

	// Sticky error flags, write one to clear; a new event beats the clear
	assign st_set[`PAB_ST_UNSUP] = take & chk & unsup;
	assign st_set[`PAB_ST_MISAL] = take & misal;
	assign st_clr = (wr_acc && (paddr == `PAB_OFF_STATUS)) ? pwdata[1:0] : 2'h0;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			status_r <= 2'h0;
		else
			status_r <= (status_r & ~st_clr) | st_set;
	end

	// Count of beats sent to memory, wraps silently
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			count_r <= 32'h0;
		else if (issue)
			count_r <= count_r + 32'h1;
	end

	// Every output comes straight from a flip-flop
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign req_ready = req_ready_r;
	assign mem_req = mem_req_r;
	assign done = done_r;
	assign fetch_flush = fetch_flush_r;

endmodule : pab_page_attribute_byte_order

// ===== tb/pab_checker.sv
`timescale 1ns/1ps
module pab_checker
(
	input wire logic                     sys_clk,
	input wire logic                     rst,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pready,
	input wire logic                     req_ready,
	input wire pab_pkg::pab_req_type     req,
	input wire pab_pkg::pab_mem_req_type mem_req,
	input wire pab_pkg::pab_done_type    done,
	input wire logic                     fetch_flush
);
	import pab_pkg::*;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	logic tk;
	logic st;
	// Taken request, and taken store on a plain cacheable page
	assign tk = req.valid && req_ready;
	assign st = tk && req.kind == KIND_STORE && req.attrs_valid && req.attrs[4:2] == 3'b000;
	apb_ready_a: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	wi_refuse_a: assert property (tk && req.kind == KIND_STORE && req.attrs_valid && req.attrs[4:3] == 2'b11
		|=> done.valid && done.err && !mem_req.valid) else $error("W with I accepted");
	load_busy_a: assert property (tk && req.kind == KIND_LOAD && req.size == SZ_BYTE && req.attrs_valid
		&& req.attrs[4:2] == 3'b000 |=> !req_ready && mem_req.valid && mem_req.op == MOP_READ)
		else $error("load not issued");
	byte_lane_a: assert property (st && req.size == SZ_BYTE |=> mem_req.be == 8'h01 << $past(req.addr[2:0])
		&& 8'(mem_req.data >> {$past(req.addr[2:0]), 3'b000}) == $past(req.data[7:0])) else $error("byte lane");
	be_msb_a: assert property (st && req.size == SZ_WORD && req.attrs[0] == 1'b0 && req.addr[2:0] == 3'h0
		|=> mem_req.data[7:0] == $past(req.data[31:24])) else $error("big end order");
	le_lsb_a: assert property (st && req.size == SZ_WORD && req.attrs[0] && req.addr[2:0] == 3'h0
		|=> mem_req.data[7:0] == $past(req.data[7:0])) else $error("little end order");
	cmo_ok_a: assert property (tk && req.kind == KIND_CMO
		|=> done.valid && !done.err && mem_req.op == MOP_CMO) else $error("cache op refused");
	isync_flush_a: assert property (tk && req.kind == KIND_ISYNC |=> fetch_flush && !mem_req.valid)
		else $error("isync without flush");
endmodule : pab_checker

bind pab_page_attribute_byte_order pab_checker u_chk (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
	.pready(pready), .req_ready(req_ready), .req(req), .mem_req(mem_req), .done(done), .fetch_flush(fetch_flush));

// ===== tb/pab_mem_model.sv
`timescale 1ns/1ps
module pab_mem_model
(
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	input  wire logic [3:0]               lat,
	input  wire pab_pkg::pab_mem_req_type mem_req,
	output pab_pkg::pab_mem_rsp_type      mem_rsp
);
	import pab_pkg::*;
	logic [63:0] mem_r [0:3];
	logic [3:0]  wait_r;
	logic [1:0]  idx_r;
	logic        pend_r;
	// Writes land per lane; reads answer lat+2 cycles after the read beat
	always_ff @(posedge sys_clk)
	begin
		mem_rsp.valid <= 1'b0;
		mem_rsp.data <= ~mem_rsp.data; // Off the pulse the data inverts each cycle, so the last word shows every other cycle
		if (rst)
		begin
			pend_r <= 1'b0;
			mem_rsp.data <= '0;
		end
		else if (mem_req.valid && mem_req.op == MOP_READ)
		begin
			pend_r <= 1'b1;
			wait_r <= lat;
			idx_r <= mem_req.addr[4:3];
		end
		else if (mem_req.valid && mem_req.op inside {MOP_WRITE, MOP_ZERO})
		begin
			// The model holds no cache, so no stale copy of a CI line can exist
			for (int k = 0; k < 8; k++)
				if (mem_req.be[k])
					mem_r[mem_req.addr[4:3]][8*k+:8] <= mem_req.op == MOP_ZERO ? 8'h00 : mem_req.data[8*k+:8];
		end
		else if (pend_r && wait_r == 4'h0)
		begin
			pend_r <= 1'b0;
			mem_rsp <= '{1'b1, mem_r[idx_r]};
		end
		else if (pend_r)
			wait_r <= wait_r - 4'h1;
	end
endmodule : pab_mem_model

// ===== tb/pab_page_attribute_byte_order_test.sv
`timescale 1ns/1ps
module pab_page_attribute_byte_order_test;
	import pab_pkg::*;
	logic            sys_clk = 0;
	logic            rst = 1;
	logic            psel = 0;
	logic            penable = 0;
	logic            pwrite = 0;
	logic [11:0]     paddr = '0;
	logic [31:0]     pwdata = '0;
	logic [31:0]     prdata;
	logic [31:0]     rd;
	logic            pready, pslverr, req_ready, fetch_flush, er, ff;
	logic [3:0]      lat = 4'h0;
	pab_req_type     req = '0;
	pab_mem_req_type mem_req, mq;
	pab_mem_rsp_type mem_rsp;
	pab_done_type    done, dq;
	int              fail_count = 0;
	int              checks_done = 0;
	int              cyc = 0;
	always #25 sys_clk = ~sys_clk;
	pab_page_attribute_byte_order uut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
		.req_ready(req_ready), .mem_req(mem_req), .mem_rsp(mem_rsp), .done(done), .fetch_flush(fetch_flush));
	pab_mem_model mem (.sys_clk(sys_clk), .rst(rst), .lat(lat), .mem_req(mem_req), .mem_rsp(mem_rsp));
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// One APB transfer; held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// One pipeline request; collects the memory op, flush pulse and answer
	task automatic op(input pab_kind_type k, input pab_size_type s, input logic [31:0] a, input logic [63:0] d,
		input logic [3:0] n, input logic v, input logic [4:0] at);
		mq = '0;
		ff = 1'b0;
		@(posedge sys_clk);
		req <= '{1'b1, k, s, a, d, n, v, at};
		do @(posedge sys_clk); while (req_ready !== 1'b1);
		req.valid <= 1'b0;
		for (int i = 0; i < 40; i++)
		begin
			#1;
			if (mem_req.valid === 1'b1)
				mq = mem_req;
			if (fetch_flush === 1'b1)
				ff = 1'b1;
			if (done.valid === 1'b1)
				break;
			@(posedge sys_clk);
		end
		dq = done;
		chk("done", dq.valid, 1'b1);
	endtask : op
	task automatic t_regs();
		apb(0, 12'h000, 0);
		chk("attrs", rd, 32'h08);
		apb(0, 12'hff0, 0);
		chk("unmapped", er, 1'b1);
		op(KIND_STORE, SZ_WORD, 32'h0, 64'h1, 0, 0, 0);
		chk("dflt ci", mq.ci, 1'b1);
		$display("registers done");
	endtask : t_regs
	task automatic t_scalar();
		op(KIND_STORE, SZ_WORD, 32'h4, 64'h11121314, 0, 1, 5'h00);
		chk("be", mq.be, 8'hf0);
		chk("big", mq.data[63:32], 32'h14131211);
		op(KIND_STORE, SZ_WORD, 32'h4, 64'h11121314, 0, 1, 5'h01);
		chk("little", mq.data[63:32], 32'h11121314);
		op(KIND_STORE, SZ_WORD, 32'h0, 64'h11121314, 0, 1, 5'h00);
		chk("big lo", mq.data[31:0], 32'h14131211);
		op(KIND_STORE, SZ_WORD, 32'h0, 64'h11121314, 0, 1, 5'h01);
		chk("little lo", mq.data[31:0], 32'h11121314);
		lat <= 4'h3;
		op(KIND_LOAD, SZ_WORD, 32'h4, 0, 0, 1, 5'h01);
		chk("rdback", dq.data, 64'h11121314);
		op(KIND_LOAD, SZ_WORD, 32'h4, 0, 0, 1, 5'h00);
		chk("alias", dq.data, 64'h14131211);
		op(KIND_STORE, SZ_DWORD, 32'h8, 64'h2122232425262728, 0, 1, 5'h00);
		op(KIND_LOAD, SZ_DWORD, 32'h8, 0, 0, 1, 5'h00);
		chk("dword", dq.data, 64'h2122232425262728);
		op(KIND_STORE, SZ_BYTE, 32'h3, 64'hab, 0, 1, 5'h01);
		chk("byte", mq.data[31:24], 8'hab);
		op(KIND_LOAD, SZ_BYTE, 32'h3, 0, 0, 1, 5'h01);
		chk("byte ld", dq.data, 64'hab);
		$display("scalars done");
	endtask : t_scalar
	task automatic t_string();
		op(KIND_STSW, SZ_WORD, 32'h10, 64'h50000000_4c4d4e4f, 4'h5, 1, 5'h01);
		chk("str be", mq.be, 8'h1f);
		chk("str mem", mq.data[39:0], 40'h504f4e4d4c);
		op(KIND_LSW, SZ_WORD, 32'h10, 0, 4'h5, 1, 5'h00);
		chk("str ld", dq.data, 64'h50000000_4c4d4e4f);
		$display("strings done");
	endtask : t_string
	task automatic t_attrs();
		for (int a = 0; a < 8; a++)
		begin
			op(KIND_STORE, SZ_WORD, 32'h0, 64'h1, 0, 1, 5'({a[2], ~a[2], 1'b0, a[1:0]}));
			chk("ge", dq.err, 1'b0);
			chk("grd", mq.grd, a[1]);
			chk("wt", mq.wt, a[2]);
		end
		op(KIND_STORE, SZ_WORD, 32'h0, 64'h1, 0, 1, 5'h18);
		chk("wi", mq.valid, 1'b0);
		op(KIND_CMO, SZ_WORD, 32'h0, 0, 0, 1, 5'h00);
		op(KIND_STORE, SZ_WORD, 32'h0, 64'h1, 0, 1, 5'h04);
		chk("m on", dq.err, 1'b0);
		apb(1, 12'h00c, 0);
		op(KIND_STORE, SZ_WORD, 32'h0, 64'h1, 0, 1, 5'h04);
		chk("m off", dq.err, 1'b1);
		apb(1, 12'h00c, 1);
		op(KIND_CMO, SZ_WORD, 32'h0, 0, 0, 1, 5'h08);
		chk("cmo", dq.err, 1'b0);
		op(KIND_ICBI, SZ_WORD, 32'h0, 0, 0, 1, 5'h08);
		chk("icbi", mq.op, MOP_ICBI);
		op(KIND_ISYNC, SZ_WORD, 32'h0, 0, 0, 1, 5'h08);
		chk("isync", ff, 1'b1);
		op(KIND_STORE, SZ_WORD, 32'h6, 64'h1, 0, 1, 5'h00);
		chk("misal", dq.err, 1'b1);
		chk("misal mem", mq.valid, 1'b0);
		apb(0, 12'h004, 0);
		chk("status", rd, 32'h3);
		apb(1, 12'h004, 32'h3);
		apb(0, 12'h004, 0);
		chk("status clr", rd, 32'h0);
		$display("attributes done");
	endtask : t_attrs
	// A hang counts as a mismatch
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			close_out();
		end
	end
	initial
	begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs();
		t_scalar();
		t_string();
		t_attrs();
		close_out();
	end
endmodule : pab_page_attribute_byte_order_test
